// >>> cpc_defines.vh
// register map, field positions and reset values of the clock path configuration bank
`ifndef CPC_DEFINES_VH
`define CPC_DEFINES_VH
`define CPC_ADDR_W           16
`define CPC_REF_SRC_ADDR     16'h090E
`define CPC_IO_VSEL_ADDR     16'h0943
`define CPC_IN_CTRL_ADDR     16'h0949
`define CPC_IN_PD_EN_ADDR    16'h094A
`define CPC_HYS_LO_ADDR      16'h094E
`define CPC_HYS_HI_ADDR      16'h094F
`define CPC_MULT_INT_ADDR    16'h095E
`define CPC_DIV_CLK_EN_ADDR  16'h0A03
`define CPC_DIV_BYP_ADDR     16'h0A04
`define CPC_DIV_PWR_ADDR     16'h0A05
`define CPC_INIT_A_ADDR      16'h0B24
`define CPC_INIT_B_ADDR      16'h0B25
`define CPC_FRAC_GATE_ADDR   16'h0B44
`define CPC_LOOP_GATE_ADDR   16'h0B45
`define CPC_SIG_LOSS_GATE_ADDR 16'h0B46
`define CPC_FREQ_OFS_GATE_ADDR 16'h0B47
`define CPC_FREQ_OFS_DIV_ADDR  16'h0B48
`define CPC_DIV_DIS_ADDR     16'h0B4A
`define CPC_INIT_C_ADDR      16'h0B4E
`define CPC_CAL_LO_ADDR      16'h0B57
`define CPC_CAL_HI_ADDR      16'h0B58
`define CPC_SOFT_RST_ADDR    16'h001C
`define CPC_SOFT_RST_BIT     0
`define CPC_BUF_EN_LSB       0
`define CPC_IN_PULSED_LSB    4
`define CPC_LOOP0_FRAC_BIT   4
`define CPC_LOOP1_FRAC_BIT   5
`define CPC_REG_RESET        8'h00
`endif

// >>> cpc_byte_reg.v
// one byte-wide configuration register with a writable-bit mask
`timescale 1ns/1ns
module cpc_byte_reg #(
  parameter [15:0] ADDR  = 16'h0000,
  parameter [7:0]  MASK  = 8'hFF,
  parameter [7:0]  RST_V = 8'h00
) (
  input  wire        ref_clk,
  input  wire        rst_b,
  input  wire        soft_rst,
  input  wire        wr_en,
  input  wire [15:0] addr,
  input  wire [7:0]  wdata,
  output wire        hit,
  output reg  [7:0]  q_r
);
  assign hit = (addr == ADDR);
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      q_r <= RST_V & MASK;
    end else if (soft_rst) begin
      q_r <= RST_V & MASK;
    end else if (wr_en && hit) begin
      // undefined bits stay zero whatever is written
      q_r <= wdata & MASK;
    end
  end
endmodule // cpc_byte_reg

// >>> cpc_config_regs.v
// clock path configuration register bank with decoded control outputs
//
// Functional notes
// - ref source bit0: crystal clear, oscillator set
// - io voltage bit0: 1.8V clear, 3.3V set
// - low nibble enables input buffers, else powerdown
// - high nibble selects pulsed single-ended input format for enabled inputs only
// - input n uses bits n and n+4
// - loop divider clocks run only when enabled
// - bypass bit chooses integer-only over fractional division
// - divider power bit zero powers loop divider down
// - predivider fraction clock gate, one disables
// - bits 4,5 gate loop feedback fraction clock
// - signal loss detector clock gate per input
// - five-bit divider clock disable, bits 0 and 1 stop loop dividers
// - hysteresis field spans two bytes, 12 bits
`timescale 1ns/1ns
`include "cpc_defines.vh"
module cpc_config_regs #(
  parameter N_IN   = 4,
  parameter N_LOOP = 2
) (
  input  wire                   ref_clk,
  input  wire                   rst_b,
  input  wire                   wr_en,
  input  wire                   rd_en,
  input  wire [`CPC_ADDR_W-1:0] addr,
  input  wire [7:0]             wdata,
  output reg  [7:0]             rdata_r,
  output reg                    rd_hit_r,
  output wire                   soft_rst_pulse,
  output wire                   ext_osc_sel,
  output wire                   io_3v3_sel,
  output wire [N_IN-1:0]        in_buf_en,
  output wire [N_IN-1:0]        in_buf_pwr_down,
  output wire [N_IN-1:0]        in_pulsed_fmt,
  output wire [N_IN-1:0]        input_to_phase_detector_enable,
  output wire [11:0]            input_hysteresis_select,
  output wire                   ref_multiplier_integer_mode,
  output wire [N_LOOP-1:0]      loop_divider_run,
  output wire [N_LOOP-1:0]      divider_bypass,
  output wire [N_LOOP-1:0]      divider_power,
  output wire [N_IN-1:0]        predivider_fraction_clk_on,
  output wire [N_LOOP-1:0]      loop_fraction_clk_on,
  output wire [N_LOOP-1:0]      loop_clock_on,
  output wire [N_IN-1:0]        signal_loss_detector_clk_on,
  output wire [4:0]             freq_offset_detector_gate,
  output wire [4:0]             freq_offset_divider_gate,
  output wire [4:0]             loop_divider_clock_disable,
  output wire [23:0]            init_control,
  output wire [11:0]            oscillator_cal_code
);
  localparam NREG = 20;

  wire [7:0]    q [0:NREG-1];
  wire [NREG-1:0] hit;
  reg           soft_rst_r;

  // soft reset register reads zero; a one in bit 0 resets the bank, all but the io voltage byte, next cycle
  assign soft_rst_pulse = soft_rst_r;
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      soft_rst_r <= 1'b0;
    end else begin
      soft_rst_r <= wr_en && (addr == `CPC_SOFT_RST_ADDR) &&
                    wdata[`CPC_SOFT_RST_BIT];
    end
  end

  // masks hold only the defined bits of each byte
  cpc_byte_reg #(.ADDR(`CPC_REF_SRC_ADDR), .MASK(8'h01)) u_r0 (
    .ref_clk(ref_clk), .rst_b(rst_b), .soft_rst(soft_rst_r), .wr_en(wr_en),
    .addr(addr), .wdata(wdata), .hit(hit[0]), .q_r(q[0]));
  cpc_byte_reg #(.ADDR(`CPC_IO_VSEL_ADDR), .MASK(8'h01)) u_r1 (
    .ref_clk(ref_clk), .rst_b(rst_b), .soft_rst(1'b0), .wr_en(wr_en),
    .addr(addr), .wdata(wdata), .hit(hit[1]), .q_r(q[1]));
  cpc_byte_reg #(.ADDR(`CPC_IN_CTRL_ADDR), .MASK(8'hFF)) u_r2 (
    .ref_clk(ref_clk), .rst_b(rst_b), .soft_rst(soft_rst_r), .wr_en(wr_en),
    .addr(addr), .wdata(wdata), .hit(hit[2]), .q_r(q[2]));
  cpc_byte_reg #(.ADDR(`CPC_IN_PD_EN_ADDR), .MASK(8'h0F)) u_r3 (
    .ref_clk(ref_clk), .rst_b(rst_b), .soft_rst(soft_rst_r), .wr_en(wr_en),
    .addr(addr), .wdata(wdata), .hit(hit[3]), .q_r(q[3]));
  cpc_byte_reg #(.ADDR(`CPC_HYS_LO_ADDR), .MASK(8'hFF)) u_r4 (
    .ref_clk(ref_clk), .rst_b(rst_b), .soft_rst(soft_rst_r), .wr_en(wr_en),
    .addr(addr), .wdata(wdata), .hit(hit[4]), .q_r(q[4]));
  cpc_byte_reg #(.ADDR(`CPC_HYS_HI_ADDR), .MASK(8'h0F)) u_r5 (
    .ref_clk(ref_clk), .rst_b(rst_b), .soft_rst(soft_rst_r), .wr_en(wr_en),
    .addr(addr), .wdata(wdata), .hit(hit[5]), .q_r(q[5]));
  cpc_byte_reg #(.ADDR(`CPC_MULT_INT_ADDR), .MASK(8'h01)) u_r6 (
    .ref_clk(ref_clk), .rst_b(rst_b), .soft_rst(soft_rst_r), .wr_en(wr_en),
    .addr(addr), .wdata(wdata), .hit(hit[6]), .q_r(q[6]));
  cpc_byte_reg #(.ADDR(`CPC_DIV_CLK_EN_ADDR), .MASK(8'h03)) u_r7 (
    .ref_clk(ref_clk), .rst_b(rst_b), .soft_rst(soft_rst_r), .wr_en(wr_en),
    .addr(addr), .wdata(wdata), .hit(hit[7]), .q_r(q[7]));
  cpc_byte_reg #(.ADDR(`CPC_DIV_BYP_ADDR), .MASK(8'h03)) u_r8 (
    .ref_clk(ref_clk), .rst_b(rst_b), .soft_rst(soft_rst_r), .wr_en(wr_en),
    .addr(addr), .wdata(wdata), .hit(hit[8]), .q_r(q[8]));
  cpc_byte_reg #(.ADDR(`CPC_DIV_PWR_ADDR), .MASK(8'h03)) u_r9 (
    .ref_clk(ref_clk), .rst_b(rst_b), .soft_rst(soft_rst_r), .wr_en(wr_en),
    .addr(addr), .wdata(wdata), .hit(hit[9]), .q_r(q[9]));
  cpc_byte_reg #(.ADDR(`CPC_INIT_A_ADDR), .MASK(8'hFF)) u_r10 (
    .ref_clk(ref_clk), .rst_b(rst_b), .soft_rst(soft_rst_r), .wr_en(wr_en),
    .addr(addr), .wdata(wdata), .hit(hit[10]), .q_r(q[10]));
  cpc_byte_reg #(.ADDR(`CPC_INIT_B_ADDR), .MASK(8'hFF)) u_r11 (
    .ref_clk(ref_clk), .rst_b(rst_b), .soft_rst(soft_rst_r), .wr_en(wr_en),
    .addr(addr), .wdata(wdata), .hit(hit[11]), .q_r(q[11]));
  cpc_byte_reg #(.ADDR(`CPC_FRAC_GATE_ADDR), .MASK(8'h3F)) u_r12 (
    .ref_clk(ref_clk), .rst_b(rst_b), .soft_rst(soft_rst_r), .wr_en(wr_en),
    .addr(addr), .wdata(wdata), .hit(hit[12]), .q_r(q[12]));
  cpc_byte_reg #(.ADDR(`CPC_LOOP_GATE_ADDR), .MASK(8'h03)) u_r13 (
    .ref_clk(ref_clk), .rst_b(rst_b), .soft_rst(soft_rst_r), .wr_en(wr_en),
    .addr(addr), .wdata(wdata), .hit(hit[13]), .q_r(q[13]));
  cpc_byte_reg #(.ADDR(`CPC_SIG_LOSS_GATE_ADDR), .MASK(8'h0F)) u_r14 (
    .ref_clk(ref_clk), .rst_b(rst_b), .soft_rst(soft_rst_r), .wr_en(wr_en),
    .addr(addr), .wdata(wdata), .hit(hit[14]), .q_r(q[14]));
  cpc_byte_reg #(.ADDR(`CPC_FREQ_OFS_GATE_ADDR), .MASK(8'h1F)) u_r15 (
    .ref_clk(ref_clk), .rst_b(rst_b), .soft_rst(soft_rst_r), .wr_en(wr_en),
    .addr(addr), .wdata(wdata), .hit(hit[15]), .q_r(q[15]));
  cpc_byte_reg #(.ADDR(`CPC_FREQ_OFS_DIV_ADDR), .MASK(8'h1F)) u_r16 (
    .ref_clk(ref_clk), .rst_b(rst_b), .soft_rst(soft_rst_r), .wr_en(wr_en),
    .addr(addr), .wdata(wdata), .hit(hit[16]), .q_r(q[16]));
  cpc_byte_reg #(.ADDR(`CPC_DIV_DIS_ADDR), .MASK(8'h1F)) u_r17 (
    .ref_clk(ref_clk), .rst_b(rst_b), .soft_rst(soft_rst_r), .wr_en(wr_en),
    .addr(addr), .wdata(wdata), .hit(hit[17]), .q_r(q[17]));
  cpc_byte_reg #(.ADDR(`CPC_INIT_C_ADDR), .MASK(8'hFF)) u_r18 (
    .ref_clk(ref_clk), .rst_b(rst_b), .soft_rst(soft_rst_r), .wr_en(wr_en),
    .addr(addr), .wdata(wdata), .hit(hit[18]), .q_r(q[18]));
  cpc_byte_reg #(.ADDR(`CPC_CAL_LO_ADDR), .MASK(8'hFF)) u_r19 (
    .ref_clk(ref_clk), .rst_b(rst_b), .soft_rst(soft_rst_r), .wr_en(wr_en),
    .addr(addr), .wdata(wdata), .hit(hit[19]), .q_r(q[19]));

  // cal code high byte is kept apart so the array stays one decode per entry
  wire       cal_hi_hit;
  wire [7:0] cal_hi_q;
  cpc_byte_reg #(.ADDR(`CPC_CAL_HI_ADDR), .MASK(8'h0F)) u_r20 (
    .ref_clk(ref_clk), .rst_b(rst_b), .soft_rst(soft_rst_r), .wr_en(wr_en),
    .addr(addr), .wdata(wdata), .hit(cal_hi_hit), .q_r(cal_hi_q));

  // read mux: unmapped addresses and the soft reset byte return zero
  reg [7:0] rd_mux;
  reg       rd_any;
  integer   i;
  always @* begin
    rd_mux = 8'h00;
    rd_any = cal_hi_hit;
    if (cal_hi_hit) begin
      rd_mux = cal_hi_q;
    end
    for (i = 0; i < NREG; i = i + 1) begin
      if (hit[i]) begin
        rd_mux = rd_mux | q[i];
        rd_any = 1'b1;
      end
    end
  end

  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata_r  <= 8'h00;
      rd_hit_r <= 1'b0;
    end else if (rd_en) begin
      rdata_r  <= rd_mux;
      rd_hit_r <= rd_any;
    end
  end

  assign ext_osc_sel = q[0][0];
  // io level stays across soft reset so the serial link keeps its thresholds
  assign io_3v3_sel  = q[1][0];

  genvar n;
  generate
    for (n = 0; n < N_IN; n = n + 1) begin : g_in
      assign in_buf_en[n]       = q[2][`CPC_BUF_EN_LSB + n];
      assign in_buf_pwr_down[n] = ~q[2][`CPC_BUF_EN_LSB + n];
      // format only matters while the buffer is powered
      assign in_pulsed_fmt[n]   = q[2][`CPC_IN_PULSED_LSB + n] &
                                  q[2][`CPC_BUF_EN_LSB + n];
      assign predivider_fraction_clk_on[n]  = ~q[12][n];
      assign signal_loss_detector_clk_on[n] = ~q[14][n] & in_buf_en[n];
    end
    for (n = 0; n < N_LOOP; n = n + 1) begin : g_loop
      // a divider runs only with enable, power and no disable together
      assign loop_divider_run[n] = q[7][n] & q[9][n] & ~q[17][n];
      assign loop_clock_on[n]    = ~q[13][n];
    end
  endgenerate

  assign input_to_phase_detector_enable = q[3][N_IN-1:0];
  assign input_hysteresis_select        = {q[5][3:0], q[4]};
  assign ref_multiplier_integer_mode    = q[6][0];
  assign divider_bypass                 = q[8][N_LOOP-1:0];
  assign divider_power                  = q[9][N_LOOP-1:0];
  assign loop_fraction_clk_on = {~q[12][`CPC_LOOP1_FRAC_BIT],
                                 ~q[12][`CPC_LOOP0_FRAC_BIT]};
  assign freq_offset_detector_gate      = q[15][4:0];
  assign freq_offset_divider_gate       = q[16][4:0];
  assign loop_divider_clock_disable     = q[17][4:0];
  assign init_control                   = {q[18], q[11], q[10]};
  assign oscillator_cal_code            = {cal_hi_q[3:0], q[19]};
endmodule // cpc_config_regs

// >>> cpc_config_regs_monitor.sv
// concurrent checks on the configuration bank ports
`timescale 1ns/1ns
module cpc_config_monitor (
  input wire logic        ref_clk,
  input wire logic        rst_b,
  input wire logic        wr_en,
  input wire logic        rd_en,
  input wire logic [15:0] addr,
  input wire logic [7:0]  wdata,
  input wire logic [7:0]  rdata_r,
  input wire logic        rd_hit_r,
  input wire logic        soft_rst_pulse,
  input wire logic        ext_osc_sel,
  input wire logic        io_3v3_sel,
  input wire logic [3:0]  in_buf_en,
  input wire logic [3:0]  in_buf_pwr_down,
  input wire logic [3:0]  in_pulsed_fmt,
  input wire logic [1:0]  loop_divider_run,
  input wire logic [1:0]  divider_power,
  input wire logic [4:0]  loop_divider_clock_disable,
  input wire logic [3:0]  signal_loss_detector_clk_on
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  // a soft reset beats a write landing in the same cycle, so such writes are left out
  wire wok = wr_en && !soft_rst_pulse;
  a_src_sel_follow: assert property (wok && addr == 16'h090E |=> ext_osc_sel == $past(wdata[0]))
    else $error("reference source select did not follow write");
  a_io_sel_follow: assert property (wr_en && addr == 16'h0943 |=> io_3v3_sel == $past(wdata[0]))
    else $error("io voltage select did not follow write");
  a_buf_power_down: assert property (in_buf_pwr_down == ~in_buf_en)
    else $error("buffer power down not inverse of enable");
  a_pulsed_per_input: assert property (wok && addr == 16'h0949 |=> in_pulsed_fmt == ($past(wdata[7:4]) & $past(wdata[3:0])))
    else $error("pulsed format bits wrong");
  a_loop_run_gated: assert property ((loop_divider_run & ~(divider_power & ~loop_divider_clock_disable[1:0])) == 2'h0)
    else $error("loop divider runs while powered down or disabled");
  a_loss_needs_buf: assert property ((signal_loss_detector_clk_on & ~in_buf_en) == 4'h0)
    else $error("signal loss clock on for disabled input");
  a_soft_pulse_issue: assert property (wr_en && addr == 16'h001C && wdata[0] |=> soft_rst_pulse)
    else $error("soft reset pulse missing");
  a_soft_clear_regs: assert property (soft_rst_pulse && !wr_en |=> !ext_osc_sel && in_buf_en == 4'h0)
    else $error("soft reset did not clear registers");
  a_unmapped_read: assert property (rd_en && addr == 16'h0A06 |=> !rd_hit_r && rdata_r == 8'h00)
    else $error("unmapped read returned data");
  a_hold_idle: assert property (!wr_en && !soft_rst_pulse |=> $stable(in_buf_en) && $stable(ext_osc_sel))
    else $error("register changed without a write");
  c_soft_reset: cover property (soft_rst_pulse);
  c_one_loop: cover property (loop_divider_run == 2'h1);
  c_unmapped: cover property (rd_en && addr == 16'h0A06);
endmodule // cpc_config_monitor

bind cpc_config_regs cpc_config_monitor mon_u (.ref_clk, .rst_b, .wr_en, .rd_en, .addr, .wdata,
  .rdata_r, .rd_hit_r, .soft_rst_pulse, .ext_osc_sel, .io_3v3_sel, .in_buf_en, .in_buf_pwr_down,
  .in_pulsed_fmt, .loop_divider_run, .divider_power, .loop_divider_clock_disable,
  .signal_loss_detector_clk_on);

// >>> cpc_host_model.sv
// serial host stand-in that issues register writes and reads
`timescale 1ns/1ns
module cpc_host_model (
  input  wire logic ref_clk,
  output logic      wr_en = 1'b0,
  output logic      rd_en = 1'b0,
  output logic [15:0] addr = 16'h0000,
  output logic [7:0]  wdata = 8'h00
);
  // idle lines carry the inverse so a stale value never passes for a live one
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge ref_clk);
    wr_en <= 1'b0;
    addr <= ~a;
    wdata <= ~d;
    // caller looks at the outputs only once the launching edge has settled
    #1;
  endtask
  task automatic rd(input logic [15:0] a);
    @(posedge ref_clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge ref_clk);
    rd_en <= 1'b0;
    addr <= ~a;
  endtask
  task automatic host_3v3;
    wr(16'h0943, 8'h01);
  endtask
  task automatic set_bypass(input logic [1:0] b);
    wr(16'h0A04, {6'h00, b});
    wr(16'h001C, 8'h01);
  endtask
endmodule // cpc_host_model

// >>> cpc_config_regs_test.sv
// self-checking bench for the configuration register bank
`timescale 1ns/1ns
module cpc_config_regs_test;
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  logic rd_seen = 1'b0;
  int   fail_count = 0;
  int   checks_done = 0;
  logic [8:0] exp_q[$];
  wire wr_en, rd_en, rd_hit_r, ext_osc_sel, io_3v3_sel;
  wire [15:0] addr;
  wire [7:0] wdata, rdata_r;
  wire [3:0] buf_en, pwr_dn, pulsed, pre_on, loss_on, pd_en;
  wire [1:0] run, byp, loop_on, lclk_on;
  wire [4:0] ofs_gate, ofs_div;
  wire [11:0] hys, cal;
  wire [23:0] init_c;
  wire mult_int;
  logic [23:0] map [21] = '{24'h090E01, 24'h094301, 24'h0949FF, 24'h094A0F, 24'h094EFF,
    24'h094F0F, 24'h095E01, 24'h0A0303, 24'h0A0403, 24'h0A0503, 24'h0B24FF, 24'h0B25FF,
    24'h0B443F, 24'h0B4503, 24'h0B460F, 24'h0B471F, 24'h0B481F, 24'h0B4A1F, 24'h0B4EFF,
    24'h0B57FF, 24'h0B580F};
  always #5 ref_clk = ~ref_clk;
  cpc_host_model host_u (.ref_clk(ref_clk), .wr_en(wr_en), .rd_en(rd_en), .addr(addr),
    .wdata(wdata));
  cpc_config_regs dut_u (.ref_clk(ref_clk), .rst_b(rst_b), .wr_en(wr_en), .rd_en(rd_en),
    .addr(addr), .wdata(wdata), .rdata_r(rdata_r), .rd_hit_r(rd_hit_r), .soft_rst_pulse(),
    .ext_osc_sel(ext_osc_sel), .io_3v3_sel(io_3v3_sel), .in_buf_en(buf_en),
    .in_buf_pwr_down(pwr_dn), .in_pulsed_fmt(pulsed), .input_to_phase_detector_enable(pd_en),
    .input_hysteresis_select(hys), .ref_multiplier_integer_mode(mult_int),
    .loop_divider_run(run),
    .divider_bypass(byp), .divider_power(), .predivider_fraction_clk_on(pre_on),
    .loop_fraction_clk_on(loop_on), .loop_clock_on(lclk_on),
    .signal_loss_detector_clk_on(loss_on),
    .freq_offset_detector_gate(ofs_gate), .freq_offset_divider_gate(ofs_div),
    .loop_divider_clock_disable(), .init_control(init_c), .oscillator_cal_code(cal));
  task automatic check(input string nm, input logic [23:0] seen, input logic [23:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic rdx(input logic [15:0] a, input logic h, input logic [7:0] d);
    exp_q.push_back({h, d});
    host_u.rd(a);
  endtask
  // read results land one cycle after the strobe is taken
  always @(posedge ref_clk) begin
    rd_seen <= rd_en;
    if (rd_seen) check("read", {3'h0, rd_hit_r, rdata_r}, {3'h0, exp_q.pop_front()});
  end
  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    #100000;
    fail_count++;
    complete_run;
  end
  initial begin
    logic [7:0] v;
    void'($urandom(83));
    repeat (5) @(posedge ref_clk);
    rst_b <= 1'b1;
    foreach (map[i]) rdx(map[i][23:8], 1'b1, 8'h00);
    rdx(16'h0A06, 1'b0, 8'h00);
    $display("test reset values done");
    foreach (map[i]) begin
      v = 8'($urandom);
      host_u.wr(map[i][23:8], v);
      rdx(map[i][23:8], 1'b1, v & map[i][7:0]);
    end
    $display("test readback done");
    for (int b = 0; b < 2; b++) begin
      host_u.wr(16'h090E, 8'hFE | b[7:0]);
      check("ext_osc", ext_osc_sel, b[23:0]);
    end
    host_u.wr(16'h0943, 8'h00);
    check("io_sel", io_3v3_sel, 24'h0);
    host_u.host_3v3;
    check("io_sel", io_3v3_sel, 24'h1);
    // input 2 pulsed and enabled, input 1 pulsed but disabled
    host_u.wr(16'h0949, 8'h65);
    check("buf_en", buf_en, 24'h5);
    check("pwr_dn", pwr_dn, 24'hA);
    check("pulsed", pulsed, 24'h4);
    host_u.wr(16'h094E, 8'hC3);
    host_u.wr(16'h094F, 8'hF9);
    check("hys", hys, 24'h9C3);
    host_u.wr(16'h0A03, 8'h03);
    host_u.wr(16'h0A05, 8'h03);
    host_u.wr(16'h0B4A, 8'h02);
    check("run", run, 24'h1);
    host_u.wr(16'h0A03, 8'h02);
    check("run", run, 24'h0);
    host_u.wr(16'h0B44, 8'h1A);
    check("pre_on", pre_on, 24'h5);
    check("loop_on", loop_on, 24'h2);
    host_u.wr(16'h0B46, 8'h03);
    check("loss_on", loss_on, 24'h4);
    host_u.wr(16'h094A, 8'hF6);
    check("pd_en", pd_en, 24'h6);
    host_u.wr(16'h095E, 8'hFF);
    check("mult_int", mult_int, 24'h1);
    host_u.wr(16'h0B45, 8'hFE);
    check("lclk_on", lclk_on, 24'h1);
    host_u.wr(16'h0B47, 8'hEA);
    check("ofs_gate", ofs_gate, 24'h0A);
    host_u.wr(16'h0B48, 8'hF5);
    check("ofs_div", ofs_div, 24'h15);
    host_u.wr(16'h0B24, 8'h12);
    host_u.wr(16'h0B25, 8'h34);
    host_u.wr(16'h0B4E, 8'h56);
    check("init", init_c, 24'h563412);
    host_u.wr(16'h0B57, 8'h9A);
    host_u.wr(16'h0B58, 8'hFB);
    check("cal", cal, 24'h000B9A);
    $display("test decoded outputs done");
    host_u.set_bypass(2'h3);
    check("bypass", byp, 24'h3);
    @(posedge ref_clk);
    #1;
    check("ext_osc", ext_osc_sel, 24'h0);
    check("io_sel", io_3v3_sel, 24'h1);
    rdx(16'h0949, 1'b1, 8'h00);
    rdx(16'h0A04, 1'b1, 8'h00);
    repeat (3) @(posedge ref_clk);
    $display("test soft reset done");
    complete_run;
  end
endmodule // cpc_config_regs_test
